// ===== rtl/urif_pkg.sv
// constants, field layouts and carrier types of the serial port register block
// Behaviour
// - data read returns oldest received character
// - data write queues next character to send
// - peek port usable only with peek enabled
// - peek read pops transmit, write pushes receive
// - status shows both fill counts, reset zero
// - status shows both full flags, reset zero
// - status shows receive half, transmit below half
// - status flags frame, parity, lost, break errors
// - transmit empty and shift idle reset one
// - rx_avail set while a character waits
// - fifo_present reads one, read only
// - interrupt when transmit shifter becomes idle
// - held receive interrupt after quiet interval
// - interrupt on every received break
// - level interrupts from both fill levels
// - external tick replaces divider when selected
// - loop_test_en wires transmitter to receiver
// - handshake_en applies clear and request flow
// - parity enable and odd or even select
// - interrupts for transmit fifo drained and received characters
// - tx_on and rx_on enable, reset off
// - divider register holds 20 bit reload
// - divider counts down, ticks, reloads on underflow
// - error flags sticky until written zero
`default_nettype none
package urif_pkg;
    // word offsets of the five registers
    localparam logic [4:0] OFF_DATA = 5'h00;
    localparam logic [4:0] OFF_STATE = 5'h04;
    localparam logic [4:0] OFF_CFG = 5'h08;
    localparam logic [4:0] OFF_BAUD = 5'h0C;
    localparam logic [4:0] OFF_PEEK = 5'h10;
    // both directions are built with fifos
    localparam logic FIFO_PRESENT = 1'b1;
    // fifo geometry and half level
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] FIFO_HALF = 4'h4;
    // ticks per bit and half-bit start check
    localparam logic [2:0] TICK_LAST = 3'h7;
    localparam logic [2:0] START_LAST = 3'h3;
    // frame lengths in bits, with and without parity
    localparam logic [3:0] FRAME_NP = 4'hA;
    localparam logic [3:0] FRAME_P = 4'hB;
    // quiet interval for the held receive interrupt, in ticks
    localparam int HOLD_CHARS = 4;
    localparam int HOLD_BITS = 4;
    localparam int TICKS_PER_BIT = 8;
    localparam logic [8:0] HOLD_NP = 9'((HOLD_CHARS * 10 + HOLD_BITS) * TICKS_PER_BIT);
    localparam logic [8:0] HOLD_P = 9'((HOLD_CHARS * 11 + HOLD_BITS) * TICKS_PER_BIT);
    // reset values
    localparam logic [14:0] CFG_RST = 15'h0000;
    localparam logic [3:0] ERR_RST = 4'h0;
    localparam logic [19:0] BAUD_RST = 20'h00000;
    // configuration bits 14 down to 0, bit 0 last
    typedef struct packed {
        logic shift_idle_irq_en;
        logic rx_irq_hold_en;
        logic zero_frame_irq_en;
        logic fifo_peek_en;
        logic rx_level_irq_en;
        logic tx_level_irq_en;
        logic ext_tick_sel;
        logic loop_test_en;
        logic handshake_en;
        logic parity_on;
        logic odd_parity_sel;
        logic tx_done_irq_en;
        logic rx_char_irq_en;
        logic tx_on;
        logic rx_on;
    } urif_cfg_s;
    // sticky error flags, status bits 6 down to 3
    typedef struct packed {
        logic frame_err;
        logic parity_bad;
        logic lost_char_flag;
        logic rx_zero_frame_flag;
    } urif_err_s;
    typedef enum logic [1:0] {URIF_TX_IDLE = 2'b01, URIF_TX_BUSY = 2'b10} urif_tx_e;
    typedef enum logic [2:0] {
        URIF_RX_IDLE = 3'b001,
        URIF_RX_START = 3'b010,
        URIF_RX_DATA = 3'b100
    } urif_rx_e;
endpackage
`default_nettype wire

// ===== rtl/urif_core.sv
// serial port register block with its fifos, divider and frame engines
`default_nettype none

// simple synchronous fifo, power-of-two depth
module urif_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D+1)-1:0] fill
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    // whole fifo state
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } urif_fifo_s;
    urif_fifo_s st_ff;
    urif_fifo_s nxt_st;
    logic push; // accepted write
    logic pop; // accepted read

    // honest full and empty straight from the count
    assign in_ready = (st_ff.cnt != CW'(D));
    assign out_valid = (st_ff.cnt != '0);
    assign out_data = st_ff.mem[st_ff.rp];
    assign fill = st_ff.cnt;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointer and count update
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wp] = in_data;
            nxt_st.wp = AW'(st_ff.wp + 1'b1);
        end
        if (pop) begin
            nxt_st.rp = AW'(st_ff.rp + 1'b1);
        end
        // simultaneous push and pop leaves the count alone
        if (push && !pop) begin
            nxt_st.cnt = CW'(st_ff.cnt + 1'b1);
        end else if (pop && !push) begin
            nxt_st.cnt = CW'(st_ff.cnt - 1'b1);
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule // urif_fifo

// register block top
module urif_core (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    input wire logic cts_n,
    output logic rts_n,
    input wire logic ext_baud_clock_in,
    output logic irq
);
    // all block state
    typedef struct packed {
        urif_pkg::urif_cfg_s cfg;
        urif_pkg::urif_err_s err;
        logic [19:0] baud; // divider reload
        logic [19:0] scale; // divider count
        logic ext_prev; // last external clock level
        urif_pkg::urif_tx_e txs;
        logic [10:0] tsh; // transmit frame, lsb goes out first
        logic [3:0] tleft; // bits still to send
        logic [2:0] ttk; // tick within a bit
        urif_pkg::urif_rx_e rxs;
        logic [9:0] rsh; // receive assembly, enters at top
        logic [3:0] rleft; // samples still to take
        logic [2:0] rtk;
        logic [8:0] hcnt; // quiet interval countdown
        logic pend; // held receive interrupt pending
        logic txe_prev; // transmit fifo was empty
        logic [31:0] rdata;
        logic txl; // internal transmit line
        logic txd;
        logic rts_n;
        logic irq;
    } urif_core_s;
    localparam urif_core_s CORE_RST = '{
        cfg: urif_pkg::urif_cfg_s'(urif_pkg::CFG_RST),
        err: urif_pkg::urif_err_s'(urif_pkg::ERR_RST),
        baud: urif_pkg::BAUD_RST, scale: urif_pkg::BAUD_RST, ext_prev: 1'b0,
        txs: urif_pkg::URIF_TX_IDLE, tsh: 11'h7FF, tleft: 4'h0, ttk: 3'h0,
        rxs: urif_pkg::URIF_RX_IDLE, rsh: 10'h000, rleft: 4'h0, rtk: 3'h0,
        hcnt: 9'h000, pend: 1'b0, txe_prev: 1'b1, rdata: 32'h00000000,
        txl: 1'b1, txd: 1'b1, rts_n: 1'b0, irq: 1'b0
    };
    urif_core_s st_ff;
    urif_core_s nxt_st;

    // fifo hookup
    logic tx_push, tx_in_ready, tx_valid, tx_pop;
    logic rx_push, rx_in_ready, rx_valid, rx_pop;
    logic [7:0] tx_head, rx_head, rx_in;
    logic [3:0] tx_fill, rx_fill;
    // bus decode
    logic mapped, setup, rd_acc, wr_acc, st_wr;
    logic [4:0] off;
    // engine helpers, filled by the combinational process
    logic tick, rline, tx_go, shift_done, rx_done, rx_store, brk_ev, rx_ev;
    logic rx_lvl, tx_lvl;
    logic [7:0] rchar;
    logic [9:0] rsh_n;
    logic frm_bad, par_bad;

    urif_fifo #(.W(urif_pkg::DATA_W), .D(urif_pkg::FIFO_DEPTH)) u_tx_fifo (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .in_valid(tx_push), .in_ready(tx_in_ready), .in_data(pwdata[7:0]),
        .out_valid(tx_valid), .out_ready(tx_pop), .out_data(tx_head), .fill(tx_fill)
    );
    urif_fifo #(.W(urif_pkg::DATA_W), .D(urif_pkg::FIFO_DEPTH)) u_rx_fifo (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .in_valid(rx_push), .in_ready(rx_in_ready), .in_data(rx_in),
        .out_valid(rx_valid), .out_ready(rx_pop), .out_data(rx_head), .fill(rx_fill)
    );

    // zero wait state slave; upper address bits must be clear
    assign off = paddr[4:0];
    assign mapped = (paddr[7:5] == 3'h0) && (off == urif_pkg::OFF_DATA ||
        off == urif_pkg::OFF_STATE || off == urif_pkg::OFF_CFG ||
        off == urif_pkg::OFF_BAUD || off == urif_pkg::OFF_PEEK);
    assign setup = psel & ~penable;
    assign rd_acc = psel & penable & ~pwrite & mapped;
    assign wr_acc = psel & penable & pwrite & mapped;
    assign st_wr = wr_acc && off == urif_pkg::OFF_STATE;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = st_ff.rdata;
    assign txd = st_ff.txd;
    assign rts_n = st_ff.rts_n;
    assign irq = st_ff.irq;

    // next state of the whole block
    always_comb begin
        nxt_st = st_ff;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        rx_in = pwdata[7:0];
        shift_done = 1'b0;
        rx_done = 1'b0;
        rx_store = 1'b0;
        brk_ev = 1'b0;
        nxt_st.scale = (st_ff.scale == 20'h00000) ? st_ff.baud : 20'(st_ff.scale - 20'h00001);
        nxt_st.ext_prev = ext_baud_clock_in;
        tick = st_ff.cfg.ext_tick_sel ? (ext_baud_clock_in & ~st_ff.ext_prev)
                                      : (st_ff.scale == 20'h00000);

        // register reads are captured in the setup phase
        if (setup) begin
            unique case (off)
                urif_pkg::OFF_DATA: nxt_st.rdata = {24'h000000, rx_head};
                urif_pkg::OFF_STATE: nxt_st.rdata = {2'h0, rx_fill, 2'h0, tx_fill, 9'h000,
                    ~rx_in_ready, ~tx_in_ready, rx_fill >= urif_pkg::FIFO_HALF,
                    tx_fill < urif_pkg::FIFO_HALF, st_ff.err, ~tx_valid,
                    st_ff.txs == urif_pkg::URIF_TX_IDLE, rx_valid};
                urif_pkg::OFF_CFG: nxt_st.rdata = {urif_pkg::FIFO_PRESENT, 16'h0000, st_ff.cfg};
                urif_pkg::OFF_BAUD: nxt_st.rdata = {12'h000, st_ff.baud};
                urif_pkg::OFF_PEEK: nxt_st.rdata = st_ff.cfg.fifo_peek_en ?
                    {24'h000000, tx_head} : 32'h00000000;
                default: nxt_st.rdata = 32'h00000000;
            endcase
        end

        // register writes and read side effects in the access phase
        if (rd_acc && off == urif_pkg::OFF_DATA) begin
            rx_pop = 1'b1;
        end
        if (rd_acc && off == urif_pkg::OFF_PEEK && st_ff.cfg.fifo_peek_en) begin
            tx_pop = 1'b1;
        end
        // data write queues character; a full fifo drops it
        if (wr_acc && off == urif_pkg::OFF_DATA) begin
            tx_push = 1'b1;
        end
        if (wr_acc && off == urif_pkg::OFF_CFG) begin
            nxt_st.cfg = urif_pkg::urif_cfg_s'(pwdata[14:0]);
        end
        if (wr_acc && off == urif_pkg::OFF_BAUD) begin
            nxt_st.baud = pwdata[19:0];
        end
        if (st_wr) begin
            nxt_st.err = st_ff.err & urif_pkg::urif_err_s'(pwdata[6:3]);
        end
        if (wr_acc && off == urif_pkg::OFF_PEEK && st_ff.cfg.fifo_peek_en) begin
            rx_push = 1'b1;
        end

        // transmitter; peek mode holds it so software can drain the fifo
        // clear to send gate, looped to our own request in loop mode
        tx_go = st_ff.cfg.tx_on & ~st_ff.cfg.fifo_peek_en & tx_valid & ~tx_pop &
            (~st_ff.cfg.handshake_en |
             ~(st_ff.cfg.loop_test_en ? st_ff.rts_n : cts_n));
        unique case (st_ff.txs)
            urif_pkg::URIF_TX_IDLE: begin
                if (tx_go) begin
                    tx_pop = 1'b1;
                    if (st_ff.cfg.parity_on) begin
                        nxt_st.tsh = {1'b1, ^tx_head ^ st_ff.cfg.odd_parity_sel, tx_head, 1'b0};
                        nxt_st.tleft = urif_pkg::FRAME_P;
                    end else begin
                        nxt_st.tsh = {2'h3, tx_head, 1'b0};
                        nxt_st.tleft = urif_pkg::FRAME_NP;
                    end
                    nxt_st.ttk = 3'h0;
                    nxt_st.txs = urif_pkg::URIF_TX_BUSY;
                end
            end
            urif_pkg::URIF_TX_BUSY: begin
                if (!st_ff.cfg.tx_on) begin
                    nxt_st.txs = urif_pkg::URIF_TX_IDLE;
                    shift_done = 1'b1;
                end else if (tick) begin
                    nxt_st.ttk = 3'(st_ff.ttk + 3'h1);
                    if (st_ff.ttk == urif_pkg::TICK_LAST) begin
                        nxt_st.tsh = {1'b1, st_ff.tsh[10:1]};
                        nxt_st.tleft = 4'(st_ff.tleft - 4'h1);
                        if (st_ff.tleft == 4'h1) begin
                            nxt_st.txs = urif_pkg::URIF_TX_IDLE;
                            shift_done = 1'b1;
                        end
                    end
                end
            end
            default: nxt_st.txs = urif_pkg::URIF_TX_IDLE;
        endcase
        nxt_st.txl = (st_ff.txs == urif_pkg::URIF_TX_BUSY) ? st_ff.tsh[0] : 1'b1;
        // pin stays idle in loop mode
        nxt_st.txd = (st_ff.cfg.loop_test_en | st_ff.cfg.fifo_peek_en) ? 1'b1 : nxt_st.txl;

        // receiver; loop feeds own line
        rline = st_ff.cfg.loop_test_en ? st_ff.txl : rxd;
        rsh_n = {rline, st_ff.rsh[9:1]};
        rchar = st_ff.cfg.parity_on ? rsh_n[7:0] : rsh_n[8:1];
        frm_bad = ~rsh_n[9];
        par_bad = st_ff.cfg.parity_on & (rsh_n[8] != (^rchar ^ st_ff.cfg.odd_parity_sel));
        unique case (st_ff.rxs)
            urif_pkg::URIF_RX_IDLE: begin
                if (st_ff.cfg.rx_on && !rline) begin
                    nxt_st.rtk = 3'h0;
                    nxt_st.rxs = urif_pkg::URIF_RX_START;
                end
            end
            urif_pkg::URIF_RX_START: begin
                // re-check the start bit half a bit later
                if (!st_ff.cfg.rx_on) begin
                    nxt_st.rxs = urif_pkg::URIF_RX_IDLE;
                end else if (tick) begin
                    nxt_st.rtk = 3'(st_ff.rtk + 3'h1);
                    if (st_ff.rtk == urif_pkg::START_LAST) begin
                        nxt_st.rtk = 3'h0;
                        nxt_st.rleft = 4'(st_ff.cfg.parity_on ? urif_pkg::FRAME_P - 4'h1
                                                              : urif_pkg::FRAME_NP - 4'h1);
                        nxt_st.rxs = rline ? urif_pkg::URIF_RX_IDLE : urif_pkg::URIF_RX_DATA;
                    end
                end
            end
            urif_pkg::URIF_RX_DATA: begin
                if (!st_ff.cfg.rx_on) begin
                    nxt_st.rxs = urif_pkg::URIF_RX_IDLE;
                end else if (tick) begin
                    nxt_st.rtk = 3'(st_ff.rtk + 3'h1);
                    if (st_ff.rtk == urif_pkg::TICK_LAST) begin
                        nxt_st.rsh = rsh_n;
                        nxt_st.rleft = 4'(st_ff.rleft - 4'h1);
                        if (st_ff.rleft == 4'h1) begin
                            rx_done = 1'b1;
                            nxt_st.rxs = urif_pkg::URIF_RX_IDLE;
                        end
                    end
                end
            end
            default: nxt_st.rxs = urif_pkg::URIF_RX_IDLE;
        endcase
        // error flags at byte boundary; set wins over clear
        if (rx_done) begin
            brk_ev = frm_bad & (rchar == 8'h00) & ~(st_ff.cfg.parity_on & rsh_n[8]);
            // a debug push in the same cycle takes the fifo port, so count it as lost
            rx_store = ~frm_bad & ~par_bad & rx_in_ready & ~rx_push;
            nxt_st.err.frame_err = nxt_st.err.frame_err | frm_bad;
            nxt_st.err.parity_bad = nxt_st.err.parity_bad | par_bad;
            nxt_st.err.lost_char_flag = nxt_st.err.lost_char_flag |
                (~frm_bad & ~par_bad & ~rx_store);
            nxt_st.err.rx_zero_frame_flag = nxt_st.err.rx_zero_frame_flag | brk_ev;
        end
        if (rx_store) begin
            rx_push = 1'b1;
            rx_in = rchar;
        end
        // request to send drops while receive fifo is full
        nxt_st.rts_n = st_ff.cfg.handshake_en & ~rx_in_ready;

        // interrupt sources, one combined level out
        // fill level interrupts
        rx_lvl = st_ff.cfg.rx_level_irq_en & st_ff.cfg.rx_on & (rx_fill >= urif_pkg::FIFO_HALF);
        tx_lvl = st_ff.cfg.tx_level_irq_en & st_ff.cfg.tx_on & (tx_fill < urif_pkg::FIFO_HALF);
        rx_ev = rx_push;
        nxt_st.txe_prev = ~tx_valid;
        if (st_ff.pend && tick && st_ff.hcnt != 9'h000) begin
            nxt_st.hcnt = 9'(st_ff.hcnt - 9'h001);
        end
        if (rx_ev && st_ff.cfg.rx_char_irq_en && st_ff.cfg.rx_irq_hold_en) begin
            nxt_st.pend = 1'b1;
            nxt_st.hcnt = st_ff.cfg.parity_on ? urif_pkg::HOLD_P : urif_pkg::HOLD_NP;
        end else if (rx_lvl || (st_ff.pend && st_ff.hcnt == 9'h000)) begin
            // a level interrupt already reports the waiting character
            nxt_st.pend = 1'b0;
        end
        nxt_st.irq = rx_lvl | tx_lvl |
            (st_ff.cfg.tx_done_irq_en & st_ff.cfg.tx_on & ~st_ff.txe_prev & ~tx_valid) |
            (st_ff.cfg.rx_char_irq_en & ~st_ff.cfg.rx_irq_hold_en & (rx_ev | brk_ev)) |
            (st_ff.pend & ~rx_lvl & st_ff.hcnt == 9'h000) |
            (st_ff.cfg.zero_frame_irq_en & brk_ev) |
            (st_ff.cfg.shift_idle_irq_en & shift_done);
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= CORE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_tx_load;
        $rose(st_ff.txs == urif_pkg::URIF_TX_BUSY) && !st_ff.cfg.loop_test_en &&
            !st_ff.cfg.fifo_peek_en;
    endsequence
    sequence s_line_hold;
        !st_ff.cfg.loop_test_en && !st_ff.cfg.fifo_peek_en;
    endsequence

    a_tick_reload: assert property (
        (st_ff.scale == 20'h00000) |=> (st_ff.scale == $past(st_ff.baud)))
        else $error("divider did not reload on underflow");
    a_start_bit_out: assert property (
        s_tx_load ##1 s_line_hold |-> (txd == 1'b0))
        else $error("frame did not open with a start bit");
    a_err_sticky: assert property (
        (st_ff.err != 4'h0 && !st_wr) |=> ((st_ff.err & $past(st_ff.err)) == $past(st_ff.err)))
        else $error("error flag dropped without a write");
    a_peek_blocked: assert property (
        (rd_acc && off == urif_pkg::OFF_PEEK && !st_ff.cfg.fifo_peek_en &&
         !tx_go) |-> !tx_pop)
        else $error("peek read popped while peek disabled");
    a_tx_off_idle: assert property (
        !st_ff.cfg.tx_on |=> (st_ff.txs == urif_pkg::URIF_TX_IDLE))
        else $error("transmitter ran while disabled");
    a_loop_quiet: assert property (
        st_ff.cfg.loop_test_en |=> txd)
        else $error("pin driven during loop mode");
    a_rx_pop_one: assert property (
        (rd_acc && off == urif_pkg::OFF_DATA && rx_valid && !rx_push) |=>
        (rx_fill == 4'($past(rx_fill) - 4'h1)))
        else $error("data read did not pop one character");
    a_cfg_present: assert property (
        (setup && off == urif_pkg::OFF_CFG && paddr[7:5] == 3'h0) |=>
        (prdata[31] == urif_pkg::FIFO_PRESENT && prdata[30:15] == 16'h0000))
        else $error("configuration read shows wrong fixed bits");
    a_idle_bit: assert property (
        (setup && off == urif_pkg::OFF_STATE && paddr[7:5] == 3'h0) |=>
        (prdata[2:1] == {!$past(tx_valid), $past(st_ff.txs) == urif_pkg::URIF_TX_IDLE}))
        else $error("status idle bits wrong");
endmodule // urif_core
`default_nettype wire

// ===== verif/urif_term.sv
// serial terminal model on the far side of the line
`default_nettype none
module urif_term (
    input wire logic core_clk,
    input wire logic txd,
    output var logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    // eight clocks per bit while the divider reload is zero
    localparam int BIT_CLK = 8;
    // idle line stays high between frames
    initial rxd = 1'b1;
    // start bit, data lsb first, stop bit; a low stop level forces a bad frame
    task automatic send(input logic [7:0] ch, input logic stop_lvl);
        logic [9:0] fr;
        fr = {stop_lvl, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge core_clk);
            rxd = fr[i];
            repeat (BIT_CLK - 1) @(negedge core_clk);
        end
        @(negedge core_clk);
        rxd = 1'b1;
        repeat (BIT_CLK * 2) @(negedge core_clk);
    endtask
    // bounded wait for a start bit, then sample each data bit near its middle
    task automatic recv(output logic [7:0] ch, output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 400 && !ok; n++) begin
            @(negedge core_clk);
            ok = !txd;
        end
        // falling edges keep the look away from the edge that moves the pin
        repeat (BIT_CLK / 2) @(negedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLK) @(negedge core_clk);
            ch[i] = txd;
        end
    endtask
endmodule // urif_term
`default_nettype wire

// ===== verif/test_urif_core.sv
// self-checking bench for the serial port register block
`default_nettype none
module test_urif_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, txd, rxd, rts_n, irq, err, ok;
    logic [7:0] ch;
    logic cts_n = 1'b0; // far side clear to send
    logic ext_clk = 1'b0; // external tick source
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    always #5 core_clk = ~core_clk;
    urif_core DUT (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n),
        .ext_baud_clock_in(ext_clk), .irq(irq));
    urif_term partner (.core_clk(core_clk), .txd(txd), .rxd(rxd));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // setup, then access answered at the next rising edge, then idle
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk);
        psel = 1'b1;
        penable = 1'b0;
        pwrite = wr;
        paddr = a;
        pwdata = d;
        @(negedge core_clk);
        penable = 1'b1;
        @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        @(negedge core_clk);
        psel = 1'b0;
        penable = 1'b0;
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // reset values, read-only presence bit, divider width, unmapped offset
    task automatic t_regs;
        bus(1'b0, 8'h04, 32'h0);
        chk("status", rd, 32'h00000086);
        bus(1'b1, 8'h08, 32'h7FFF0000);
        bus(1'b0, 8'h08, 32'h0);
        chk("config", rd, 32'h80000000);
        // a large reload would stall the tick for a million clocks after it lands
        bus(1'b1, 8'h0C, 32'hFFF00003);
        bus(1'b0, 8'h0C, 32'h0);
        chk("baud", rd, 32'h00000003);
        bus(1'b1, 8'h0C, 32'h0);
        bus(1'b0, 8'h14, 32'h0);
        chk("unmapped", {30'h0, pready, err}, 32'h3);
    endtask
    // peek port locked, then fill receive side and drain both sides
    task automatic t_peek;
        bus(1'b1, 8'h10, 32'h55);
        bus(1'b0, 8'h04, 32'h0);
        chk("locked", rd, 32'h00000086);
        bus(1'b1, 8'h08, 32'h840);
        for (int i = 0; i < 8; i++) bus(1'b1, 8'h10, 32'hFFFFFF00 | i);
        bus(1'b0, 8'h04, 32'h0);
        chk("rx full", rd, 32'h20000587);
        chk("rts", {31'h0, rts_n}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 8'h00, 32'h0);
            chk("rx data", rd, i);
        end
        for (int i = 0; i < 3; i++) bus(1'b1, 8'h00, 32'hC0 + i);
        bus(1'b0, 8'h04, 32'h0);
        chk("tx fill", rd, 32'h00300082);
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, 8'h10, 32'h0);
            chk("peek pop", rd, 32'hC0 + i);
        end
    endtask
    // a real frame in, a break and its sticky flags, then a real frame out
    task automatic t_link;
        bus(1'b1, 8'h08, 32'h3);
        partner.send(8'hA5, 1'b1);
        bus(1'b0, 8'h04, 32'h0);
        chk("rx avail", rd, 32'h04000087);
        bus(1'b0, 8'h00, 32'h0);
        chk("rx char", rd, 32'hA5);
        partner.send(8'h00, 1'b0);
        bus(1'b0, 8'h04, 32'h0);
        chk("break", rd, 32'h000000CE);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b0, 8'h04, 32'h0);
        chk("cleared", rd, 32'h00000086);
        bus(1'b1, 8'h00, 32'h3C);
        partner.recv(ch, ok);
        chk("tx char", {23'h0, ok, ch}, 32'h13C);
    endtask
    // clear-to-send gate, locked peek, then ticks only from the external clock
    task automatic t_flow;
        repeat (20) @(negedge core_clk);
        cts_n = 1'b1;
        bus(1'b1, 8'h08, 32'h142);
        bus(1'b1, 8'h00, 32'h81);
        bus(1'b0, 8'h10, 32'h0);
        chk("peek off", rd, 32'h0);
        bus(1'b0, 8'h04, 32'h0);
        chk("cts held", rd, 32'h00100082);
        cts_n = 1'b0;
        bus(1'b0, 8'h04, 32'h0);
        chk("no tick", rd, 32'h00000084);
        for (int i = 0; i < 180; i++) begin
            @(negedge core_clk);
            ext_clk = ~ext_clk;
        end
        bus(1'b0, 8'h04, 32'h0);
        chk("ext done", rd, 32'h00000086);
    endtask
    // looped frame with odd parity, transmit level interrupt on
    task automatic t_loop;
        bus(1'b1, 8'h08, 32'h2B3);
        bus(1'b1, 8'h00, 32'h5A);
        chk("level irq", {31'h0, irq}, 32'h1);
        repeat (40) @(negedge core_clk);
        chk("pin idle", {31'h0, txd}, 32'h1);
        repeat (80) @(negedge core_clk);
        bus(1'b0, 8'h04, 32'h0);
        chk("loop status", rd, 32'h04000087);
        bus(1'b0, 8'h00, 32'h0);
        chk("loop char", rd, 32'h5A);
    endtask
    // cut a hang short well beyond the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        t_regs();
        t_peek();
        t_link();
        t_flow();
        t_loop();
        end_sim();
    end
endmodule // test_urif_core
`default_nettype wire
